/* logic/seeh_ctrl.sv */
// seeh_ctrl: spi host that drives a 4096-byte serial eeprom over its pins
// assumes: the eeprom is the only party on the pins; write data is queued in the fifo
//
// How it works
// RULE1: select low for a frame, high between.
// RULE2: device finishes program cycle despite select.
// RULE3: device output floats while deselected; the model drives the inverse of its last bit instead.
// RULE4: select rise after write starts program.
// RULE5: select driven low once after power-up.
// RULE6: data out on falling, sample on rising.
// RULE7: pin low plus enable refuses status write.
// RULE8: pin fall mid-program has no effect.
// RULE9: enable bit clear makes pin ignored.
// RULE10: pause falls only while serial clock low.
// RULE11: pause rises only while serial clock low.
// RULE12: keep select low and clock still paused.
// RULE13: device output floats during pause; the model drives the inverse of its last bit instead.
// RULE14: every byte goes most significant first.
// RULE15: read 03, write 02, latch clear 04.
// RULE16: latch set 06, status read 05, write 01.
// RULE17: read sends opcode then 16-bit address.
// RULE18: reads stream on, address wraps at 0fff.
// RULE19: latch set needs its own select rise.
// RULE20: write at most 32 bytes in page.
// RULE21: device wraps page overrun inside page.
// RULE22: raise select right after a whole byte.
// RULE23: poll status while busy, no array reads.
// RULE24: status bit layout: busy, latch, guard, enable.
// RULE25: guard code selects protected address range.
// RULE26: latch cleared after write instructions.
// RULE27: internal write lasts at most 5 ms.
// RULE28: unknown opcodes are ignored by device.
`timescale 1ns/1ns
module seeh_ctrl
	import seeh_pkg::*;
#(
	parameter int WRITE_TIMEOUT_CYC = WRITE_CYC,
	parameter int FIFO_DEPTH = PAGE_BYTES
) (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// user command port
	input wire logic cmd_valid_i,
	input wire logic [2:0] cmd_i,
	input wire logic [15:0] cmd_addr_i,
	input wire logic [5:0] cmd_len_i,
	input wire logic cmd_pause_i,
	output logic cmd_ready_o,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic done_o,
	output logic timeout_o,
	// eeprom pins
	output logic sel_n_o,
	output logic sck_o,
	output logic sdi_o,
	output logic pause_n_o,
	input wire logic sdo_i
);
	typedef enum logic [2:0] {ST_IDLE, ST_OP, ST_ADDR, ST_DATA, ST_GAP, ST_POLL} seeh_st_e;

	typedef struct packed {
		logic [1:0] rst_sync;
		logic [1:0] sdo_sync;
		seeh_st_e st;
		seeh_cmd_e cmd;
		logic [15:0] addr;
		logic [5:0] len;
		logic [7:0] sh;
		logic [2:0] bitc;
		logic [4:0] div;
		logic [5:0] gap;
		logic [31:0] wcnt;
		logic polling;
		logic woke;
		logic sel_n;
		logic sck;
		logic sdi;
		logic pause_n;
		logic cmd_ready;
		logic wr_ready;
		logic [7:0] rd_data;
		logic rd_valid;
		logic done;
		logic timeout;
	} seeh_state_s;

	seeh_state_s s, next_s;
	logic rst_n;
	logic half;
	seeh_fifo_if #(.W(8)) fq ();

	assign rst_n = s.rst_sync[1];
	assign half = s.div == 5'(SCK_HALF_CYC - 1);

	// write data is queued so the user can load a page ahead of the frame
	assign fq.wdata = wr_data_i;
	assign fq.wvalid = wr_valid_i;

	seeh_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i(sys_clk_i),
		.rst_n_i(rst_n),
		.f(fq)
	);

	// ----------------------------------------------------------------
	// opcode byte for each user command
	// ----------------------------------------------------------------
	function automatic logic [7:0] opcode(input seeh_cmd_e c);
		unique case (c)
			SEEH_CMD_READ: opcode = OP_READ; // RULE15
			SEEH_CMD_WRITE: opcode = OP_WRITE; // RULE15
			SEEH_CMD_WDIS: opcode = LATCH_CLEAR_OPCODE; // RULE15
			SEEH_CMD_WEN: opcode = LATCH_SET_OPCODE; // RULE16
			SEEH_CMD_STATUS_READ_OPCODE: opcode = STATUS_READ_OPCODE; // RULE16
			SEEH_CMD_STATUS_WRITE_OPCODE: opcode = STATUS_WRITE_OPCODE; // RULE16
			default: opcode = STATUS_READ_OPCODE;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.rst_sync = {s.rst_sync[0], 1'b1};
		next_s.sdo_sync = {s.sdo_sync[0], sdo_i};
		next_s.rd_valid = 1'b0;
		next_s.done = 1'b0;
		next_s.timeout = 1'b0;
		fq.rready = 1'b0;
		// the write limit runs over the whole poll loop, not per frame
		if (s.polling) begin
			next_s.wcnt = s.wcnt + 32'd1; // RULE27
		end
		// pause moves only with the clock low and not about to rise,
		// else the device would miss an edge the host has counted
		if (!s.sck && !(s.pause_n && half)) begin
			next_s.pause_n = !cmd_pause_i; // RULE10 RULE11
			if (!s.pause_n && !cmd_pause_i) begin
				// restart the low half so the resynchronised output has settled
				next_s.div = '0; // RULE13
			end
		end
		next_s.wr_ready = fq.wready;
		unique case (s.st)
			ST_IDLE: begin
				next_s.sck = 1'b0;
				next_s.div = '0;
				if (!s.woke) begin
					// a short select pulse arms the device after power-up
					next_s.sel_n = 1'b0; // RULE5
					next_s.woke = 1'b1;
					next_s.gap = '0;
					next_s.st = ST_GAP;
					next_s.cmd_ready = 1'b0;
				end else if (cmd_valid_i && s.cmd_ready) begin
					next_s.cmd = seeh_cmd_e'(cmd_i);
					next_s.addr = cmd_addr_i & ADDR_MASK; // RULE17
					// a page write is capped at one page of data; reads stream on
					next_s.len = cmd_len_i;
					if (seeh_cmd_e'(cmd_i) == SEEH_CMD_WRITE && cmd_len_i > 6'(PAGE_BYTES)) begin
						next_s.len = 6'(PAGE_BYTES); // RULE20
					end
					next_s.sh = opcode(seeh_cmd_e'(cmd_i)); // RULE14
					next_s.sdi = next_s.sh[7]; // RULE14
					next_s.bitc = '0;
					next_s.sel_n = 1'b0; // RULE1
					next_s.cmd_ready = 1'b0;
					next_s.polling = 1'b0;
					next_s.st = ST_OP;
				end
			end
			ST_OP, ST_ADDR, ST_DATA: begin
				// the clock holds still while paused, select stays low
				if (s.pause_n) begin // RULE12
					next_s.div = half ? '0 : s.div + 5'd1;
				end
				if (s.pause_n && half) begin
					next_s.sck = !s.sck;
					if (!s.sck) begin
						// rising edge: device output is valid, sample it
						next_s.sh = {s.sh[6:0], s.sdo_sync[1]}; // RULE6
					end else begin
						// falling edge: end of a bit
						next_s.bitc = s.bitc + 3'd1;
						if (s.bitc == 3'd7) begin
							next_s.bitc = '0;
							unique case (s.st)
								ST_OP: begin
									if (s.cmd == SEEH_CMD_READ || s.cmd == SEEH_CMD_WRITE) begin
										next_s.st = ST_ADDR;
										next_s.len = s.len;
										next_s.sh = s.addr[15:8]; // RULE17
										next_s.gap = 6'd1;
									end else if (s.cmd == SEEH_CMD_STATUS_WRITE_OPCODE) begin
										next_s.st = ST_DATA;
										next_s.sh = s.addr[7:0];
										next_s.len = 6'd1;
									end else if (s.cmd == SEEH_CMD_STATUS_READ_OPCODE) begin
										next_s.st = ST_DATA;
										next_s.len = 6'd1;
									end else begin
										// latch set/clear end here so select rises
										next_s.st = ST_GAP; // RULE19
										next_s.gap = '0;
									end
								end
								ST_ADDR: begin
									if (s.gap != '0) begin
										next_s.sh = s.addr[7:0];
										next_s.gap = '0;
									end else begin
										next_s.st = ST_DATA;
										if (s.cmd == SEEH_CMD_WRITE) begin
											next_s.sh = fq.rdata;
											fq.rready = 1'b1;
										end
									end
								end
								default: begin
									if (s.cmd != SEEH_CMD_WRITE && s.cmd != SEEH_CMD_STATUS_WRITE_OPCODE) begin
										next_s.rd_data = s.sh;
										next_s.rd_valid = 1'b1;
									end
									// read pointer advances inside the device
									next_s.addr = (s.addr + 16'd1) & ADDR_MASK; // RULE18
									next_s.len = s.len - 6'd1;
									if (s.cmd == SEEH_CMD_WRITE && s.len != 6'd1) begin
										next_s.sh = fq.rdata;
										fq.rready = 1'b1;
									end
									// select rises right after the last full byte
									if (s.len == 6'd1) begin
										next_s.st = ST_GAP; // RULE22
										next_s.gap = '0;
									end
								end
							endcase
						end
						// data to the device moves only after a falling edge; the first bit goes out as select falls
						next_s.sdi = next_s.sh[7]; // RULE6 RULE14
					end
				end
			end
			ST_GAP: begin
				// select high after the frame starts any program cycle
				next_s.sel_n = 1'b1; // RULE1 RULE4
				next_s.sck = 1'b0;
				next_s.gap = s.gap + 6'd1;
				if (s.gap == 6'(DESEL_CYC)) begin
					next_s.gap = '0;
					if (s.polling && !s.rd_data[WRITE_BUSY_FLAG]) begin // RULE24
						// the last poll saw the program cycle finished
						next_s.st = ST_IDLE;
						next_s.cmd_ready = 1'b1;
						next_s.done = 1'b1;
						next_s.polling = 1'b0;
					end else if (s.cmd == SEEH_CMD_WRITE || s.cmd == SEEH_CMD_STATUS_WRITE_OPCODE) begin
						// poll the busy flag; array reads wait for it
						next_s.st = ST_POLL; // RULE23
						if (!s.polling) begin
							next_s.wcnt = '0;
						end
						next_s.polling = 1'b1;
					end else begin
						next_s.st = ST_IDLE;
						next_s.cmd_ready = 1'b1;
						next_s.done = s.woke && !s.polling;
					end
				end
			end
			ST_POLL: begin
				if (s.wcnt >= 32'(WRITE_TIMEOUT_CYC)) begin // RULE27
					next_s.st = ST_IDLE;
					next_s.cmd_ready = 1'b1;
					next_s.timeout = 1'b1;
					next_s.polling = 1'b0;
				end else begin
					// each poll is a fresh status-read frame
					next_s.sel_n = 1'b0;
					next_s.sh = STATUS_READ_OPCODE; // RULE23
					next_s.sdi = STATUS_READ_OPCODE[7]; // RULE14
					next_s.bitc = '0;
					next_s.div = '0;
					next_s.cmd = SEEH_CMD_STATUS_READ_OPCODE;
					next_s.st = ST_OP;
				end
			end
			default: next_s.st = ST_IDLE;
		endcase
		// status read results during polling also reach rd_data_o with rd_valid_o; cmd goes back to a write so the loop goes on
		if (s.polling && s.cmd == SEEH_CMD_STATUS_READ_OPCODE && next_s.st == ST_GAP) begin
			next_s.cmd = SEEH_CMD_WRITE;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s <= '{st: ST_IDLE, cmd: SEEH_CMD_STATUS_READ_OPCODE, sel_n: 1'b1, pause_n: 1'b1,
				default: '0};
		end else begin
			s <= next_s;
		end
	end

	assign cmd_ready_o = s.cmd_ready;
	assign wr_ready_o = s.wr_ready;
	assign rd_data_o = s.rd_data;
	assign rd_valid_o = s.rd_valid;
	assign done_o = s.done;
	assign timeout_o = s.timeout;
	assign sel_n_o = s.sel_n;
	assign sck_o = s.sck;
	assign sdi_o = s.sdi;
	assign pause_n_o = s.pause_n;
endmodule // seeh_ctrl

/* logic/seeh_pkg.sv */
// seeh_pkg: constants for the serial eeprom host controller
// assumes: a 250 MHz system clock and a serial eeprom on the far side of the pins
package seeh_pkg;
	localparam int SYS_CLK_MHZ = 250;
	// serial clock half period in system cycles (250 MHz / 40 = 6.25 MHz link)
	localparam int SCK_HALF_CYC = 20;
	// least gap with select high between frames, in ns
	localparam int DESEL_NS = 100;
	localparam int DESEL_CYC = (DESEL_NS * SYS_CLK_MHZ + 999) / 1000;
	// longest internal write cycle, in ms
	localparam int WRITE_MS = 5;
	localparam int WRITE_CYC = WRITE_MS * SYS_CLK_MHZ * 1000;
	// instruction codes
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_WRITE = 8'h02;
	localparam logic [7:0] LATCH_CLEAR_OPCODE = 8'h04;
	localparam logic [7:0] LATCH_SET_OPCODE = 8'h06;
	localparam logic [7:0] STATUS_READ_OPCODE = 8'h05;
	localparam logic [7:0] STATUS_WRITE_OPCODE = 8'h01;
	// status byte fields
	localparam int WRITE_BUSY_FLAG = 0;
	localparam int WRITE_LATCH_FLAG = 1;
	localparam int BLOCK_GUARD_BIT_LOW = 2;
	localparam int BLOCK_GUARD_BIT_HIGH = 3;
	localparam int PROTECT_PIN_ENABLE_BIT = 7;
	// array geometry
	localparam int ADDR_W = 16;
	localparam int PAGE_BYTES = 32;
	localparam logic [15:0] ADDR_MASK = 16'h0fff;
	// user command codes
	typedef enum logic [2:0] {
		SEEH_CMD_READ,
		SEEH_CMD_WRITE,
		SEEH_CMD_WEN,
		SEEH_CMD_WDIS,
		SEEH_CMD_STATUS_READ_OPCODE,
		SEEH_CMD_STATUS_WRITE_OPCODE
	} seeh_cmd_e;
endpackage

/* logic/seeh_fifo_if.sv */
// seeh_fifo_if: write data path between the controller and its fifo
// assumes: a single clock shared by both modports
`timescale 1ns/1ns
interface seeh_fifo_if #(parameter int W = 8);
	logic [W-1:0] wdata;
	logic wvalid;
	logic wready;
	logic [W-1:0] rdata;
	logic rvalid;
	logic rready;
	modport fifo (input wdata, input wvalid, output wready,
		output rdata, output rvalid, input rready);
	modport user (output wdata, output wvalid, input wready,
		input rdata, input rvalid, output rready);
endinterface

/* logic/seeh_fifo.sv */
// seeh_fifo: synchronous fifo with valid/ready on both sides
// assumes: one clock, active-low async reset already synchronised
`timescale 1ns/1ns
module seeh_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	seeh_fifo_if.fifo f
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} seeh_fptr_s;
	seeh_fptr_s s, next_s;
	logic [W-1:0] mem [DEPTH];
	logic full;
	logic empty;

	assign empty = s.wp == s.rp;
	assign full = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
	assign f.wready = !full;
	assign f.rvalid = !empty;
	assign f.rdata = mem[s.rp[AW-1:0]];

	always_comb begin
		next_s = s;
		if (f.wvalid && !full) begin
			next_s.wp = s.wp + 1'b1;
		end
		if (f.rready && !empty) begin
			next_s.rp = s.rp + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (f.wvalid && !full) begin
			mem[s.wp[AW-1:0]] <= f.wdata;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule // seeh_fifo

/* sim/seeh_eeprom_model.sv */
// seeh_eeprom_model: behavioural serial eeprom standing on the host pins
// assumes: pins driven by seeh_ctrl; no protect pin, so it reads as high
`timescale 1ns/1ns
module seeh_eeprom_model
	import seeh_pkg::*;
#(
	parameter int BUSY_NS = 2000,
	// level of the protect pin; high leaves the status byte writable
	parameter bit PROTECT_PIN = 1'b1
) (
	input wire logic sel_n_i,
	input wire logic sck_i,
	input wire logic sdi_i,
	input wire logic pause_n_i,
	output logic sdo_o
);
	logic [7:0] mem [4096];
	logic [7:0] sr = 8'h00;
	logic [7:0] op;
	logic [7:0] sh;
	logic [11:0] a;
	logic [19:0] pend [$];
	logic d = 1'b0;
	int n = 0;
	initial foreach (mem[j]) mem[j] = 8'hff;
	// ---------
	// pin logic
	// ---------
	// a released line shows the inverse of the last bit, never a stale copy
	assign sdo_o = (sel_n_i || !pause_n_i) ? !d : d;
	always @(negedge sel_n_i) begin
		n = 0;
		pend.delete();
	end
	always @(posedge sck_i) if (!sel_n_i && pause_n_i) begin
		sh = {sh[6:0], sdi_i};
		n++;
		if (n == 8) op = sh;
		if (n == 16 || n == 24) a = {a[3:0], sh};
		if (op == OP_WRITE && n > 24 && n % 8 == 0) begin
			pend.push_back({a, sh});
			a[4:0]++;
		end
	end
	// only the two read opcodes ever drive data, unknown ones do nothing
	always @(negedge sck_i) if (!sel_n_i && pause_n_i) begin
		if (op == STATUS_READ_OPCODE && n >= 8) d = sr[7 - n % 8];
		if (op == OP_READ && n >= 24 && !sr[0]) begin
			d = mem[a][7 - n % 8];
			if (n % 8 == 7) a++;
		end
	end
	// busy ignores select edges, so a running program cycle always ends
	always @(posedge sel_n_i) if (!sr[0]) begin
		if (n == 8 && op == LATCH_SET_OPCODE) sr[1] = 1'b1;
		if (n == 8 && op == LATCH_CLEAR_OPCODE) sr[1] = 1'b0;
		// the pin is looked at only here, so a later fall cannot touch a running cycle
		if (sr[1] && n == 16 && op == STATUS_WRITE_OPCODE && (PROTECT_PIN || !sr[7])) begin
			sr = {sh[7], 3'h0, sh[3:2], 2'b01};
		end
		if (sr[1] && op == OP_WRITE && n > 24 && n % 8 == 0) begin
			foreach (pend[j]) if (!(sr[3:2] == 2'b11 || sr[3] && pend[j][19] ||
				sr[2] && pend[j][19:18] == 2'b11)) mem[pend[j][19:8]] = pend[j][7:0];
			sr[1:0] = 2'b01;
		end
		if (sr[0]) #BUSY_NS sr[0] = 1'b0;
	end
endmodule // seeh_eeprom_model

/* sim/seeh_ctrl_assertions.sv */
// seeh_ctrl_assertions: pin timing checks on the eeprom host
// assumes: bound to seeh_ctrl, raw nrst_i as its reset
`timescale 1ns/1ns
module seeh_ctrl_assertions (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic sel_n_o,
	input wire logic sck_o,
	input wire logic sdi_o,
	input wire logic pause_n_o
);
	logic sck_q;
	logic [2:0] bits;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	// --------------------------------
	// serial bits of the frame, mod 8
	// --------------------------------
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sck_q <= 1'b0;
			bits <= 3'h0;
		end else begin
			sck_q <= sck_o;
			bits <= sel_n_o ? 3'h0 : bits + 3'(sck_o && !sck_q);
		end
	end
	property p_sck_framed;
		$rose(sck_o) |-> !sel_n_o && pause_n_o;
	endproperty
	a_sck_framed: assert property (p_sck_framed)
		else $error("sck rose outside a live frame");
	property p_pause_sck;
		$changed(pause_n_o) |-> !sck_o;
	endproperty
	a_pause_sck: assert property (p_pause_sck)
		else $error("pause moved with sck high");
	property p_pause_sel;
		!pause_n_o |-> !sel_n_o;
	endproperty
	a_pause_sel: assert property (p_pause_sel)
		else $error("pause while deselected");
	property p_sdi_hold;
		sck_o |-> $stable(sdi_o);
	endproperty
	a_sdi_hold: assert property (p_sdi_hold)
		else $error("sdi moved around sck high");
	property p_first_low;
		$fell(sel_n_o) |-> !sck_o;
	endproperty
	a_first_low: assert property (p_first_low)
		else $error("select fell with sck high");
	property p_sck_high;
		$rose(sck_o) |-> ##20 $fell(sck_o);
	endproperty
	a_sck_high: assert property (p_sck_high)
		else $error("sck high time wrong");
	property p_gap;
		$rose(sel_n_o) |=> not (##[0:23] !sel_n_o);
	endproperty
	a_gap: assert property (p_gap)
		else $error("deselect gap too short");
	property p_byte_end;
		$rose(sel_n_o) |-> bits == 3'h0;
	endproperty
	a_byte_end: assert property (p_byte_end)
		else $error("frame ended inside a byte");
endmodule // seeh_ctrl_assertions
bind seeh_ctrl seeh_ctrl_assertions chk_u (.sys_clk_i, .nrst_i, .sel_n_o, .sck_o, .sdi_o,
	.pause_n_o);

/* sim/seeh_ctrl_tb_top.sv */
// seeh_ctrl_tb_top: command-level bench for the eeprom host
// assumes: seeh_eeprom_model on the pins, short write timeout
`timescale 1ns/1ns
module seeh_ctrl_tb_top
	import seeh_pkg::*;
;
	logic sys_clk_i, nrst_i, cmd_valid_i, cmd_pause_i, wr_valid_i, sdo_i;
	logic cmd_ready_o, wr_ready_o, rd_valid_o, done_o, timeout_o;
	logic sel_n_o, sck_o, sdi_o, pause_n_o;
	logic [2:0] cmd_i;
	logic [15:0] cmd_addr_i;
	logic [5:0] cmd_len_i;
	logic [7:0] wr_data_i, rd_data_o;
	logic [7:0] rq [$];
	int failures, checks_done, i, k;
	seeh_ctrl #(.WRITE_TIMEOUT_CYC(2000)) dut_u (.sys_clk_i, .nrst_i, .cmd_valid_i, .cmd_i,
		.cmd_addr_i, .cmd_len_i, .cmd_pause_i, .cmd_ready_o, .wr_data_i, .wr_valid_i,
		.wr_ready_o, .rd_data_o, .rd_valid_o, .done_o, .timeout_o, .sel_n_o, .sck_o,
		.sdi_o, .pause_n_o, .sdo_i);
	seeh_eeprom_model eep_u (.sel_n_i(sel_n_o), .sck_i(sck_o), .sdi_i(sdi_o),
		.pause_n_i(pause_n_o), .sdo_o(sdo_i));
	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) if (rd_valid_o === 1'b1) rq.push_back(rd_data_o);
	// every write here finishes well inside the limit, so a timeout is a fault
	always @(posedge sys_clk_i) if (timeout_o === 1'b1) chk("timeout", 8'h00, {7'h0, timeout_o});
	// -----
	// tasks
	// -----
	task automatic close_out();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic hang(string nm);
		chk(nm, 8'h01, 8'h00);
		close_out();
	endtask
	task automatic run(logic [2:0] c, logic [15:0] a, logic [5:0] n);
		rq.delete();
		cmd_i <= c;
		cmd_addr_i <= a;
		cmd_len_i <= n;
		cmd_valid_i <= 1'b1;
		k = 0;
		do @(posedge sys_clk_i);
		while (cmd_ready_o !== 1'b1 && ++k < 500);
		cmd_valid_i <= 1'b0;
		if (k >= 500) hang("cmd taken");
		k = 0;
		do @(posedge sys_clk_i);
		while (done_o !== 1'b1 && ++k < 40000);
		if (k >= 40000) hang("done");
	endtask
	// re-polls while the busy flag is up
	task automatic stat(logic [7:0] e);
		for (int t = 0; t < 20; t++) begin
			run(SEEH_CMD_STATUS_READ_OPCODE, 16'h0000, 6'd1);
			if (rq.size() != 1 || rq[0][0] !== 1'b1) break;
		end
		chk("status", e, rq.size() == 1 ? rq[0] : 8'hxx);
	endtask
	initial begin
		{nrst_i, cmd_valid_i, cmd_pause_i, wr_valid_i} = 4'h0;
		{cmd_i, cmd_addr_i, cmd_len_i, wr_data_i} = '0;
		failures = 0;
		checks_done = 0;
		repeat (6) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		stat(8'h00);
		run(SEEH_CMD_STATUS_WRITE_OPCODE, 16'h0084, 6'd1);
		stat(8'h00);
		run(SEEH_CMD_WEN, 16'h0000, 6'd1);
		stat(8'h02);
		run(SEEH_CMD_WDIS, 16'h0000, 6'd1);
		stat(8'h00);
		run(SEEH_CMD_WEN, 16'h0000, 6'd1);
		run(SEEH_CMD_STATUS_WRITE_OPCODE, 16'h0084, 6'd1);
		stat(8'h84);
		for (i = 0; i < 32; i++) begin
			wr_data_i <= 8'(i * 7 + 1);
			wr_valid_i <= 1'b1;
			k = 0;
			do @(posedge sys_clk_i);
			while (wr_ready_o !== 1'b1 && ++k < 50);
		end
		wr_valid_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		chk("fifo ready", 8'h00, {7'h0, wr_ready_o});
		run(SEEH_CMD_WEN, 16'h0000, 6'd1);
		run(SEEH_CMD_WRITE, 16'h0050, 6'd32);
		stat(8'h84);
		fork
			run(SEEH_CMD_READ, 16'h0040, 6'd33);
			begin
				repeat (3000) @(posedge sys_clk_i);
				cmd_pause_i <= 1'b1;
				repeat (500) @(posedge sys_clk_i);
				cmd_pause_i <= 1'b0;
			end
		join
		chk("read count", 8'd33, 8'(rq.size()));
		for (i = 0; i < 33; i++) begin
			chk("read", i < 32 ? 8'((i + 16) % 32 * 7 + 1) : 8'hff, rq[i]);
		end
		run(SEEH_CMD_READ, 16'hf040, 6'd1);
		chk("high bits", 8'h71, rq[0]);
		close_out();
	end
endmodule // seeh_ctrl_tb_top
